// File: sprc_pkg.sv
// package: register map, encodings and timing constants of the sleep/reset controller
package sprc_pkg;
    // register byte offsets (all chosen here)
    localparam logic [7:0] SPRC_SYS_CTRL_OFS = 8'h00;
    localparam logic [7:0] SPRC_PMU_CTRL_OFS = 8'h04;
    localparam logic [7:0] SPRC_DOMAIN_OFS = 8'h08;
    localparam logic [7:0] SPRC_STATUS_OFS = 8'h0C;
    localparam logic [7:0] SPRC_MIRROR_CNT_OFS = 8'h10;
    localparam logic [7:0] SPRC_TRIM_POR_OFS = 8'h14;
    localparam logic [7:0] SPRC_TRIM_HW_OFS = 8'h18;
    localparam logic [7:0] SPRC_RADIO_CTRL_OFS = 8'h1C;
    localparam logic [7:0] SPRC_GP_CTRL_OFS = 8'h20;
    localparam logic [7:0] SPRC_SCRATCH_OFS = 8'h24;
    // system control fields
    localparam int SPRC_KEEP_SYSRAM_POS = 0;
    localparam int SPRC_SOFT_RESTART_POS = 1;
    localparam int SPRC_DEEP_SLEEP_REQ_POS = 2;
    // power management control fields
    localparam int SPRC_WAKE_RESTART_POS = 0;
    // domain enable fields: per, rad, bank a..d
    localparam int SPRC_PER_POS = 0;
    localparam int SPRC_RAD_POS = 1;
    localparam int SPRC_BANK_POS = 2;
    localparam int SPRC_NUM_BANKS = 4;
    // radio control and general control retained fields
    localparam logic [31:0] SPRC_RADIO_KEEP_MASK = 32'h0000_FFFF;
    localparam logic [31:0] SPRC_DEBUG_FREEZE_MASK = 32'h0001_0000;
    localparam logic [31:0] SPRC_XMEM_MAP_MASK = 32'h0000_001F;
    // reset values
    localparam logic [31:0] SPRC_ZERO = 32'h0000_0000;
    localparam logic [31:0] SPRC_DOMAIN_RST = 32'h0000_0003;
    localparam logic [15:0] SPRC_MIRROR_CNT_RST = 16'h0000;
    // processor reset request key
    localparam logic [31:0] SPRC_CPU_RESET_KEY = 32'h05FA_0004;
    // timing: power and analog settling before cpu release
    localparam int SPRC_CLK_MHZ = 200;
    localparam int SPRC_SETTLE_NS = 100;
    localparam int SPRC_SETTLE_CYC = (SPRC_SETTLE_NS * SPRC_CLK_MHZ + 999) / 1000;
    localparam int SPRC_PULSE_CYC = 4;
    localparam logic [31:0] SPRC_DECERR = 32'h0000_0000;
    // power mode states
    typedef enum logic [5:0] {
        SPRC_ACTIVE = 6'b000001,
        SPRC_SLEEP = 6'b000010,
        SPRC_GATED = 6'b000100,
        SPRC_POWER_UP = 6'b001000,
        SPRC_MIRROR = 6'b010000,
        SPRC_RESTART = 6'b100000
    } sprc_state_e;
endpackage

// File: sprc_sync_if.sv
// interface: synchronised external events passed between modules
`timescale 1ns/10ps
interface sprc_sync_if;
    logic pad_reset;
    logic wake;
    modport src (output pad_reset, output wake);
    modport dst (input pad_reset, input wake);
endinterface

// File: sprc_sync.sv
// module: two flip-flop synchroniser for the reset pad and wake event
`timescale 1ns/10ps
module sprc_sync (
    input wire logic aclk,
    input wire logic por_n,
    input wire logic reset_pad,
    input wire logic wake_event,
    sprc_sync_if.src sync
);
    logic [1:0] stage1;
    logic [1:0] stage2;
    // only the second stage is read downstream
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            stage1 <= 2'h0;
            stage2 <= 2'h0;
        end else begin
            stage1 <= {wake_event, reset_pad};
            stage2 <= stage1;
        end
    end
    assign sync.pad_reset = stage2[0];
    assign sync.wake = stage2[1];
endmodule

// File: sprc_mirror.sv
// module: wake-time word copier from nonvolatile memory into system ram
`timescale 1ns/10ps
module sprc_mirror (
    input wire logic aclk,
    input wire logic rst,
    input wire logic start,
    input wire logic [15:0] word_count,
    input wire logic copy_ready,
    output logic copy_valid,
    output logic [15:0] copy_index,
    output logic done
);
    logic busy;
    // copies words 0..count-1 without the processor
    always_ff @(posedge aclk) begin
        if (rst) begin
            busy <= 1'b0;
            copy_index <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= (word_count != 16'h0000);
                done <= (word_count == 16'h0000);
                copy_index <= 16'h0000;
            end else if (busy && copy_ready) begin
                if (copy_index + 16'h0001 >= word_count) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                copy_index <= copy_index + 16'h0001;
            end
        end
    end
    assign copy_valid = busy;
endmodule

// File: sprc_top.sv
// module: power-mode sequencer, domain gating, retention and tiered resets
`timescale 1ns/10ps
module sprc_top
    import sprc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reset_pad,
    input wire logic wake_event,
    input wire logic cpu_sleeping,
    input wire logic cpu_reset_write,
    input wire logic [31:0] cpu_reset_data,
    input wire logic copy_ready,
    output logic copy_valid,
    output logic [15:0] copy_index,
    output logic hw_reset,
    output logic soft_reset,
    output logic cpu_hold,
    output logic boot_rom_start,
    output logic always_on_domain,
    output logic system_core_domain,
    output logic system_ram_domain,
    output logic system_ram_access,
    output logic peripheral_domain,
    output logic radio_domain,
    output logic debug_domain,
    output logic retention_bank_a_domain,
    output logic retention_bank_b_domain,
    output logic retention_bank_c_domain,
    output logic retention_bank_d_domain,
    output logic analog_enable,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    sprc_sync_if sync_bus ();
    sprc_state_e state;
    sprc_state_e next_state;
    logic por_n;
    logic hw_rst;
    logic sw_rst;
    logic any_rst;
    logic hw_or_por;
    logic soft_restart_bit;
    logic keep_system_ram_bit;
    logic deep_sleep_request_bit;
    logic wake_restart_bit;
    logic [31:0] domain_ctrl;
    logic [15:0] mirror_word_count_register;
    logic [31:0] trim_por;
    logic [31:0] trim_hw;
    logic [31:0] radio_control_register;
    logic [31:0] general_control_register;
    logic [31:0] scratch;
    logic [7:0] settle_cnt;
    logic [2:0] pulse_cnt;
    logic mirror_start;
    logic mirror_done;
    logic gated_kept_ram;
    logic [7:0] aw_ofs;
    logic [31:0] wdata_hold;
    logic [3:0] wstrb_hold;
    logic aw_full;
    logic w_full;
    logic do_write;
    logic wake_reset_req;
    logic cpu_key_hit;
    logic [31:0] wmask;
    logic [31:0] rd_value;
    logic rd_hit;

    // power-on reset stands in for the supply monitor output
    assign por_n = aresetn;
    assign hw_or_por = !por_n || hw_rst;
    assign any_rst = hw_or_por || sw_rst;
    assign cpu_key_hit = cpu_reset_write && (cpu_reset_data == SPRC_CPU_RESET_KEY);

    sprc_sync u_sync (
        .aclk(aclk),
        .por_n(por_n),
        .reset_pad(reset_pad),
        .wake_event(wake_event),
        .sync(sync_bus.src)
    );

    sprc_mirror u_mirror (
        .aclk(aclk),
        .rst(hw_or_por),
        .start(mirror_start),
        .word_count(mirror_word_count_register),
        .copy_ready(copy_ready),
        .copy_valid(copy_valid),
        .copy_index(copy_index),
        .done(mirror_done)
    );

    // hardware reset: pad level, or stretched pulse after wake restart
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            pulse_cnt <= 3'h0;
        end else if (wake_reset_req) begin
            pulse_cnt <= 3'(SPRC_PULSE_CYC);
        end else if (pulse_cnt != 3'h0) begin
            pulse_cnt <= pulse_cnt - 3'h1;
        end
    end
    assign hw_rst = sync_bus.pad_reset || (pulse_cnt != 3'h0);
    // software reset held one cycle; ored sources, registered for glitch safety
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            sw_rst <= 1'b0;
        end else begin
            sw_rst <= soft_restart_bit || cpu_key_hit;
        end
    end
    assign hw_reset = hw_rst;
    assign soft_reset = sw_rst;

    // power-on-only registers: word count and power-on trim
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            mirror_word_count_register <= SPRC_MIRROR_CNT_RST;
            trim_por <= SPRC_ZERO;
        end else if (do_write) begin
            if (aw_ofs == SPRC_MIRROR_CNT_OFS) begin
                mirror_word_count_register <= (wdata_hold[15:0] & wmask[15:0])
                    | (mirror_word_count_register & ~wmask[15:0]);
            end
            if (aw_ofs == SPRC_TRIM_POR_OFS) begin
                trim_por <= (wdata_hold & wmask) | (trim_por & ~wmask);
            end
        end
    end

    // hardware-tier registers: untouched by software reset
    always_ff @(posedge aclk) begin
        if (hw_or_por) begin
            keep_system_ram_bit <= 1'b0;
            deep_sleep_request_bit <= 1'b0;
            wake_restart_bit <= 1'b0;
            trim_hw <= SPRC_ZERO;
            radio_control_register <= SPRC_ZERO;
            general_control_register <= SPRC_ZERO;
        end else if (do_write) begin
            case (aw_ofs)
                SPRC_SYS_CTRL_OFS: begin
                    if (wstrb_hold[0]) begin
                        keep_system_ram_bit <= wdata_hold[SPRC_KEEP_SYSRAM_POS];
                        deep_sleep_request_bit <= wdata_hold[SPRC_DEEP_SLEEP_REQ_POS];
                    end
                end
                SPRC_PMU_CTRL_OFS: begin
                    if (wstrb_hold[0]) begin
                        wake_restart_bit <= wdata_hold[SPRC_WAKE_RESTART_POS];
                    end
                end
                SPRC_TRIM_HW_OFS: trim_hw <= (wdata_hold & wmask) | (trim_hw & ~wmask);
                SPRC_RADIO_CTRL_OFS: begin
                    radio_control_register <= ((wdata_hold & wmask)
                        | (radio_control_register & ~wmask))
                        & (SPRC_RADIO_KEEP_MASK | SPRC_DEBUG_FREEZE_MASK);
                end
                SPRC_GP_CTRL_OFS: begin
                    general_control_register <= ((wdata_hold & wmask)
                        | (general_control_register & ~wmask)) & SPRC_XMEM_MAP_MASK;
                end
                default: ;
            endcase
        end else if (state == SPRC_POWER_UP) begin
            deep_sleep_request_bit <= 1'b0; // request consumed on wake
        end
    end

    // any-reset registers; sleep is not a reset, so all stay retained
    always_ff @(posedge aclk) begin
        if (any_rst) begin
            domain_ctrl <= SPRC_DOMAIN_RST;
            scratch <= SPRC_ZERO;
            soft_restart_bit <= 1'b0;
        end else begin
            soft_restart_bit <= 1'b0; // self-clearing strobe
            if (do_write) begin
                if (aw_ofs == SPRC_DOMAIN_OFS) begin
                    domain_ctrl <= (wdata_hold & wmask) | (domain_ctrl & ~wmask);
                end
                if (aw_ofs == SPRC_SCRATCH_OFS) begin
                    scratch <= (wdata_hold & wmask) | (scratch & ~wmask);
                end
                if (aw_ofs == SPRC_SYS_CTRL_OFS && wstrb_hold[0]) begin
                    soft_restart_bit <= wdata_hold[SPRC_SOFT_RESTART_POS];
                end
            end
        end
    end

    // power-mode state register
    always_ff @(posedge aclk) begin
        if (hw_or_por) begin
            state <= SPRC_ACTIVE;
            gated_kept_ram <= 1'b0;
            settle_cnt <= 8'h00;
        end else begin
            state <= next_state;
            if (state == SPRC_ACTIVE && next_state == SPRC_GATED) begin
                gated_kept_ram <= keep_system_ram_bit; // mode latched at entry
            end
            if (state == SPRC_POWER_UP) begin
                settle_cnt <= settle_cnt + 8'h01;
            end else begin
                settle_cnt <= 8'h00;
            end
        end
    end

    // next mode; cpu_sleeping comes from core logic on this clock
    always_comb begin
        next_state = state;
        mirror_start = 1'b0;
        wake_reset_req = 1'b0;
        case (state)
            SPRC_ACTIVE: begin
                if (cpu_sleeping && deep_sleep_request_bit) begin
                    next_state = SPRC_GATED;
                end else if (cpu_sleeping) begin
                    next_state = SPRC_SLEEP;
                end
            end
            SPRC_SLEEP: begin
                if (!cpu_sleeping || sync_bus.wake) begin
                    next_state = SPRC_ACTIVE;
                end
            end
            SPRC_GATED: begin
                if (sync_bus.wake) begin
                    next_state = SPRC_POWER_UP;
                end
            end
            SPRC_POWER_UP: begin
                if (settle_cnt >= 8'(SPRC_SETTLE_CYC - 1)) begin
                    if (wake_restart_bit) begin
                        next_state = SPRC_RESTART;
                        wake_reset_req = 1'b1;
                    end else if (gated_kept_ram) begin
                        next_state = SPRC_ACTIVE;
                    end else begin
                        next_state = SPRC_MIRROR;
                        mirror_start = 1'b1;
                    end
                end
            end
            SPRC_MIRROR: begin
                if (mirror_done) begin
                    next_state = SPRC_ACTIVE;
                end
            end
            SPRC_RESTART: next_state = SPRC_RESTART; // left by the hardware reset
            default: next_state = SPRC_ACTIVE;
        endcase
    end

    // domain gating outputs
    assign always_on_domain = 1'b1;
    assign system_core_domain = (state != SPRC_GATED);
    assign debug_domain = (state != SPRC_GATED);
    assign system_ram_domain = (state != SPRC_GATED) || gated_kept_ram;
    assign system_ram_access = (state != SPRC_GATED) && (state != SPRC_POWER_UP);
    assign analog_enable = (state != SPRC_GATED);
    assign peripheral_domain = domain_ctrl[SPRC_PER_POS];
    assign radio_domain = domain_ctrl[SPRC_RAD_POS];
    assign retention_bank_a_domain = domain_ctrl[SPRC_BANK_POS];
    assign retention_bank_b_domain = domain_ctrl[SPRC_BANK_POS + 1];
    assign retention_bank_c_domain = domain_ctrl[SPRC_BANK_POS + 2];
    assign retention_bank_d_domain = domain_ctrl[SPRC_BANK_POS + 3];
    assign cpu_hold = (state == SPRC_GATED) || (state == SPRC_POWER_UP)
        || (state == SPRC_MIRROR) || (state == SPRC_RESTART);
    assign boot_rom_start = hw_or_por || sw_rst;

    // axi write channel capture; address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_ofs <= 8'h00;
            wdata_hold <= SPRC_ZERO;
            wstrb_hold <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_ofs <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                wdata_hold <= s_axi_wdata;
                wstrb_hold <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign s_axi_bresp = (aw_ofs > SPRC_SCRATCH_OFS || aw_ofs[1:0] != 2'h0
        || aw_ofs == SPRC_STATUS_OFS) ? 2'h3 : 2'h0;
    assign wmask = {{8{wstrb_hold[3]}}, {8{wstrb_hold[2]}},
        {8{wstrb_hold[1]}}, {8{wstrb_hold[0]}}};

    // read decode
    always_comb begin
        rd_value = SPRC_DECERR;
        rd_hit = 1'b1;
        case (s_axi_araddr[7:0])
            SPRC_SYS_CTRL_OFS: rd_value = {29'h0, deep_sleep_request_bit, 1'b0,
                keep_system_ram_bit};
            SPRC_PMU_CTRL_OFS: rd_value = {31'h0, wake_restart_bit};
            SPRC_DOMAIN_OFS: rd_value = domain_ctrl;
            SPRC_STATUS_OFS: rd_value = {25'h0, system_ram_access, state};
            SPRC_MIRROR_CNT_OFS: rd_value = {16'h0, mirror_word_count_register};
            SPRC_TRIM_POR_OFS: rd_value = trim_por;
            SPRC_TRIM_HW_OFS: rd_value = trim_hw;
            SPRC_RADIO_CTRL_OFS: rd_value = radio_control_register;
            SPRC_GP_CTRL_OFS: rd_value = general_control_register;
            SPRC_SCRATCH_OFS: rd_value = scratch;
            default: rd_hit = 1'b0;
        endcase
    end

    // axi read answer, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= SPRC_ZERO;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
endmodule

// File: sprc_top_assertions.sv
// checker: port-level properties of the sleep/reset controller
`timescale 1ns/10ps
module sprc_top_assertions
    import sprc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reset_pad,
    input wire logic cpu_reset_write,
    input wire logic [31:0] cpu_reset_data,
    input wire logic copy_ready,
    input wire logic copy_valid,
    input wire logic [15:0] copy_index,
    input wire logic hw_reset,
    input wire logic soft_reset,
    input wire logic cpu_hold,
    input wire logic boot_rom_start,
    input wire logic always_on_domain,
    input wire logic system_core_domain,
    input wire logic system_ram_domain,
    input wire logic system_ram_access,
    input wire logic debug_domain,
    input wire logic analog_enable
);
    // one domain only, so clock and disable are shared
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_ALWAYS_ON: assert property (always_on_domain)
        else $error("always-on domain dropped");
    AST_GATE_GROUP: assert property (system_core_domain == debug_domain
        && debug_domain == analog_enable)
        else $error("system, debug and analog gating disagree");
    AST_RAM_BLOCK: assert property (!system_core_domain |->
        !system_ram_access && cpu_hold)
        else $error("ram access or cpu release while gated");
    AST_RAM_ORDER: assert property (!system_ram_domain |-> !system_core_domain)
        else $error("system ram off outside gated sleep");
    AST_CPU_KEY: assert property (cpu_reset_write
        && cpu_reset_data == SPRC_CPU_RESET_KEY |-> ##[1:2] soft_reset)
        else $error("cpu reset key gave no software reset");
    // every reset tier must restart the boot path
    AST_BOOT_ON_RESET: assert property (hw_reset || soft_reset |-> boot_rom_start)
        else $error("reset without boot start");
    // a synchronised pad may not reach the reset in the very next cycle
    AST_PAD_SYNC: assert property ($rose(reset_pad) && !hw_reset |=> !hw_reset)
        else $error("reset pad used without synchroniser");
    AST_PAD_RESET: assert property (reset_pad [*3] |-> hw_reset)
        else $error("held reset pad gave no hardware reset");
    AST_COPY_HOLD: assert property (copy_valid && !copy_ready |=>
        copy_valid && $stable(copy_index))
        else $error("copy request changed while stalled");
    AST_COPY_CPU: assert property (copy_valid |-> cpu_hold)
        else $error("cpu released during mirroring");
    AST_SETTLE: assert property ($rose(system_core_domain) |-> cpu_hold [*8])
        else $error("cpu released before settling");
endmodule
bind sprc_top sprc_top_assertions u_chk (.*);

// File: sprc_cpu_model.sv
// partner: processor core and copy target as seen by the controller
`timescale 1ns/10ps
module sprc_cpu_model
    import sprc_pkg::*;
(
    input wire logic aclk,
    input wire logic sleep_cmd,
    input wire logic key_cmd,
    output logic cpu_sleeping,
    output logic cpu_reset_write,
    output logic [31:0] cpu_reset_data,
    output logic copy_ready
);
    logic [7:0] lfsr = 8'hA5;
    initial cpu_sleeping = 1'b0;
    initial cpu_reset_write = 1'b0;
    initial cpu_reset_data = 32'h0;
    initial copy_ready = 1'b0;
    // idle data inverts each cycle, so after a key write the stale key returns every second cycle
    always @(posedge aclk) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        cpu_sleeping <= sleep_cmd;
        cpu_reset_write <= key_cmd;
        cpu_reset_data <= key_cmd ? SPRC_CPU_RESET_KEY : ~cpu_reset_data;
        copy_ready <= lfsr[0];
    end
endmodule

// File: sprc_top_tb.sv
// testbench: sleep modes, retention and reset tiers over the register bus
`timescale 1ns/10ps
module sprc_top_tb;
    import sprc_pkg::*;
    logic aclk = 0, aresetn = 0, reset_pad = 0, wake_event = 0, sleep_cmd = 0, key_cmd = 0;
    logic cpu_sleeping, cpu_reset_write, copy_ready, copy_valid, hw_reset, soft_reset, cpu_hold;
    logic boot_rom_start, always_on_domain, system_core_domain, system_ram_domain;
    logic system_ram_access, peripheral_domain, radio_domain, debug_domain, analog_enable;
    logic retention_bank_a_domain, retention_bank_b_domain, retention_bank_c_domain;
    logic retention_bank_d_domain, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [31:0] cpu_reset_data, s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [31:0] v [0:9];
    logic [31:0] rd;
    logic [15:0] copy_index;
    logic [5:0] doms;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [3:0] gates;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_rvalid;
    // responses always accepted, a legal master choice
    logic s_axi_bready = 1, s_axi_rready = 1;
    int seed = 85, error_cnt = 0, n_compared = 0, n, m, b, mode;
    always #2.5 aclk = ~aclk;
    assign doms = {retention_bank_d_domain, retention_bank_c_domain, retention_bank_b_domain,
        retention_bank_a_domain, radio_domain, peripheral_domain};
    assign gates = {system_core_domain, debug_domain, analog_enable, system_ram_access};
    sprc_top DUT (.*);
    sprc_cpu_model u_cpu (.aclk(aclk), .sleep_cmd(sleep_cmd), .key_cmd(key_cmd),
        .cpu_sleeping(cpu_sleeping), .cpu_reset_write(cpu_reset_write),
        .cpu_reset_data(cpu_reset_data), .copy_ready(copy_ready));
    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd_reg(a);
        chk("rdata", e, rd);
    endtask
    // tier 0 por only, 1 por or pad, 2 any reset; k 1 soft, 2 hard
    function automatic logic [31:0] expect_val(int i, int k);
        int tier;
        tier = (i == 4 || i == 5) ? 0 : ((i > 5 && i < 9) ? 1 : 2);
        if (k > 0 && tier >= 3 - k) return (i == 2) ? SPRC_DOMAIN_RST : SPRC_ZERO;
        return v[i];
    endfunction
    task automatic chk_all(input int k);
        for (int i = 2; i < 10; i++) begin
            if (i != 3) begin
                v[i] = expect_val(i, k);
                rchk(8'(i * 4), v[i]);
            end
        end
    endtask
    // random contents, mirror count kept short to bound the copy time
    task automatic fill();
        for (int i = 2; i < 10; i++) begin
            v[i] = $random(seed) & (i == 2 ? 32'h3F : (i == 8 ? 32'h1F : 32'hFF));
            if (i == 4) v[i] = {28'h0, v[i][3:0]} + 32'h1;
            if (i != 3) wr(8'(i * 4), v[i], 2'b00);
        end
    endtask
    task automatic doze(input logic [31:0] sc);
        wr(SPRC_SYS_CTRL_OFS, sc, 2'b00);
        sleep_cmd <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask
    // wake held four cycles, counts copies, restart pulse and boot cycles
    task automatic wake_up();
        int c;
        n = 0;
        m = 0;
        b = 0;
        c = 0;
        wake_event <= 1'b1;
        sleep_cmd <= 1'b0;
        do begin
            @(posedge aclk);
            c++;
            if (c == 4) wake_event <= 1'b0;
            if (copy_valid === 1'b1 && copy_ready === 1'b1) begin
                chk("copy_index", 32'(n), {16'h0, copy_index});
                n++;
            end
            if (hw_reset === 1'b1) m++;
            if (boot_rom_start === 1'b1) b++;
        end while (c < 40 || cpu_hold !== 1'b0);
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(SPRC_DOMAIN_OFS, SPRC_DOMAIN_RST);
        rchk(SPRC_STATUS_OFS, 32'h41);
        rd_reg(8'h40);
        chk("rresp", 32'h3, {30'h0, rr});
        wr(SPRC_STATUS_OFS, 32'hFF, 2'b11);
        fill();
        wr(SPRC_SYS_CTRL_OFS, 32'h2, 2'b00);
        repeat (4) @(posedge aclk);
        chk_all(1);
        fill();
        key_cmd <= 1'b1;
        @(posedge aclk);
        key_cmd <= 1'b0;
        repeat (4) @(posedge aclk);
        chk_all(1);
        fill();
        reset_pad <= 1'b1;
        repeat (5) @(posedge aclk);
        reset_pad <= 1'b0;
        repeat (5) @(posedge aclk);
        chk_all(2);
        doze(32'h0);
        chk("core_on", 32'h1, {31'h0, system_core_domain});
        rchk(SPRC_STATUS_OFS, 32'h42);
        sleep_cmd <= 1'b0;
        repeat (3) @(posedge aclk);
        for (mode = 0; mode < 2; mode++) begin
            fill();
            doze(mode ? 32'h5 : 32'h4);
            chk("ram_dom", 32'(mode), {31'h0, system_ram_domain});
            chk("gated", 32'h0, {28'h0, gates});
            rchk(SPRC_STATUS_OFS, 32'h04);
            chk("domains", v[2], {26'h0, doms});
            wake_up();
            chk("copied", mode ? 32'h0 : v[4], 32'(n));
            chk("boot", 32'h0, 32'(b));
            chk_all(0);
        end
        wr(SPRC_PMU_CTRL_OFS, 32'h1, 2'b00);
        doze(32'h5);
        wake_up();
        chk("restart", 32'(SPRC_PULSE_CYC), 32'(m));
        chk("boot", 32'(SPRC_PULSE_CYC), 32'(b));
        chk_all(2);
        report_and_stop();
    end
    // hang guard far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        report_and_stop();
    end
endmodule
